// file: core/mpio_top.sv
`timescale 1ns/1ns
`include "mpio_map.svh"
// Overview of operation
// - Config/data pair: 00 hi-Z, 01 pull-up input, 10 drive low, 11 drive high
// - Ports L, G, C each have 8-bit config and data registers, bitwise
// - Each bidirectional port has a read-only pin level location
// - Writing one to G data bit 7 requests HALT
// - Writing one to G data bit 6 with bit 7 zero requests IDLE
// - G config bit 6 selects alternate serial clock phase
// - G config bit 7 with R/C clock enables restart delay after HALT
// - G data reads return zero in bits 6 and 7
// - G0, G2-G5 general I/O; G6 input only; G1 fault output
// - R/C option: G7 is input, its rising edge leaves HALT
// - Crystal option: G7 drives the oscillator clock output
// - All L pins feed wake-up; L4/L5 timer 2, L6/L7 timer 3
// - Port D forced all ones while reset is low
// - Port I is an eight-bit input-only port
// - G alternates: G6 SI, G5 clock, G4 SO, G3/G2 timer 1, G0 interrupt
// - Reset clears L, G, C registers, all their pins hi-Z, G1 included
module mpio_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] port_l_in,
  output logic [7:0] port_l_out,
  output logic [7:0] port_l_oe,
  output logic [7:0] port_l_pullup,
  input wire logic [7:0] port_g_in,
  output logic [7:0] port_g_out,
  output logic [7:0] port_g_oe,
  output logic [7:0] port_g_pullup,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  output logic [7:0] port_c_pullup,
  input wire logic [7:0] port_i_in,
  output logic [7:0] port_d_out,
  input wire logic rc_osc_option,
  input wire logic osc_clock_in,
  input wire logic fault_monitor_n,
  input wire logic serial_data_out,
  input wire logic serial_clock_out,
  input wire logic serial_clock_drive,
  input wire logic timer1_out,
  input wire logic timer1_drive,
  input wire logic restart_done,
  output logic halt_mode,
  output logic idle_mode,
  output logic restart_delay_enable,
  output logic serial_clock_phase_select,
  output logic [7:0] multi_input_wakeup,
  output logic timer2_input_a,
  output logic timer2_input_b,
  output logic timer3_input_a,
  output logic timer3_input_b,
  output logic timer1_capture_b,
  output logic timer1_io_a,
  output logic external_interrupt_input,
  output logic serial_data_in,
  output logic serial_shift_clock,
  output logic halt_wake
);

  logic [7:0] l_conf;
  logic [7:0] l_data;
  logic [7:0] g_conf;
  logic [7:0] g_data;
  logic [7:0] c_conf;
  logic [7:0] c_data;
  logic [7:0] d_data;
  logic [7:0] l_s1, l_s2, g_s1, g_s2, c_s1, c_s2, i_s1, i_s2;
  logic g7_prev;
  logic g7_rise;
  mpio_pkg::mpio_power_t power;
  logic [7:0] next_g_out;
  logic [7:0] next_g_oe;
  logic [7:0] next_g_pu;

  // Two flops before anything reads the pins
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      l_s1 <= 8'h00;
      l_s2 <= 8'h00;
      g_s1 <= 8'h00;
      g_s2 <= 8'h00;
      c_s1 <= 8'h00;
      c_s2 <= 8'h00;
      i_s1 <= 8'h00;
      i_s2 <= 8'h00;
    end
    else
    begin
      l_s1 <= port_l_in;
      l_s2 <= l_s1;
      g_s1 <= port_g_in;
      g_s2 <= g_s1;
      c_s1 <= port_c_in;
      c_s2 <= c_s1;
      i_s1 <= port_i_in;
      i_s2 <= i_s1;
    end
  end

  // Register writes; bidirectional ports clear on reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      l_conf <= `MPIO_PORT_RST;
      l_data <= `MPIO_PORT_RST;
      g_conf <= `MPIO_PORT_RST;
      g_data <= `MPIO_PORT_RST;
      c_conf <= `MPIO_PORT_RST;
      c_data <= `MPIO_PORT_RST;
      d_data <= `MPIO_D_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `MPIO_L_DATA: l_data <= reg_wdata;
        `MPIO_L_CONF: l_conf <= reg_wdata;
        `MPIO_G_DATA: g_data <= reg_wdata;
        `MPIO_G_CONF: g_conf <= reg_wdata;
        `MPIO_C_DATA: c_data <= reg_wdata;
        `MPIO_C_CONF: c_conf <= reg_wdata;
        `MPIO_D_DATA: d_data <= reg_wdata;
        default: ;
      endcase
    end
  end

  // HALT/IDLE state; G data bits 7/6 are write-to-request
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      power <= mpio_pkg::MPIO_RUN;
      g7_prev <= 1'b0;
    end
    else
    begin
      g7_prev <= g_s2[7];
      if (reg_wr && reg_addr == `MPIO_G_DATA &&
          reg_wdata[`MPIO_G_HALT_BIT])
        power <= mpio_pkg::MPIO_HALT;
      else if (reg_wr && reg_addr == `MPIO_G_DATA &&
               reg_wdata[`MPIO_G_IDLE_BIT])
        power <= mpio_pkg::MPIO_IDLE;
      else
      begin
        case (power)
          mpio_pkg::MPIO_HALT:
            if (g7_rise || restart_done)
              power <= mpio_pkg::MPIO_RUN;
          mpio_pkg::MPIO_IDLE:
            if (restart_done)
              power <= mpio_pkg::MPIO_RUN;
          mpio_pkg::MPIO_RUN: ;
          default: power <= mpio_pkg::MPIO_RUN;
        endcase
      end
    end
  end

  assign g7_rise = rc_osc_option && g_s2[7] && !g7_prev;

  // Port G pin drive: general bits follow config/data, driven G4 always carries SO, driven G3/G5 can be taken by alternates, others dedicated
  always_comb
  begin
    next_g_out = g_data & `MPIO_G_GPIO_MASK;
    next_g_oe = g_conf & `MPIO_G_GPIO_MASK;
    next_g_pu = ~g_conf & g_data & `MPIO_G_GPIO_MASK;
    if (serial_clock_drive && g_conf[5])
      next_g_out[5] = serial_clock_out;
    if (g_conf[4])
      next_g_out[4] = serial_data_out;
    if (timer1_drive && g_conf[3])
      next_g_out[3] = timer1_out;
    // Fault pin is open drain: drives low only on fault
    next_g_out[`MPIO_G_FAULT_BIT] = 1'b0;
    next_g_oe[`MPIO_G_FAULT_BIT] = !fault_monitor_n;
    next_g_out[7] = osc_clock_in;
    next_g_oe[7] = !rc_osc_option;
  end

  // Pin drive registers; outputs come straight from flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      port_l_out <= 8'h00;
      port_l_oe <= 8'h00;
      port_l_pullup <= 8'h00;
      port_c_out <= 8'h00;
      port_c_oe <= 8'h00;
      port_c_pullup <= 8'h00;
      port_g_out <= 8'h00;
      port_g_oe <= 8'h00;
      port_g_pullup <= 8'h00;
      port_d_out <= `MPIO_D_RST;
    end
    else
    begin
      port_l_out <= l_data;
      port_l_oe <= l_conf;
      port_l_pullup <= ~l_conf & l_data;
      port_c_out <= c_data;
      port_c_oe <= c_conf;
      port_c_pullup <= ~c_conf & c_data;
      port_g_out <= next_g_out;
      port_g_oe <= next_g_oe;
      port_g_pullup <= next_g_pu;
      port_d_out <= d_data;
    end
  end

  // Mode flags, G config outputs and side functions fed from synchronised pins
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      halt_mode <= 1'b0;
      idle_mode <= 1'b0;
      restart_delay_enable <= 1'b0;
      serial_clock_phase_select <= 1'b0;
      multi_input_wakeup <= 8'h00;
      timer2_input_a <= 1'b0;
      timer2_input_b <= 1'b0;
      timer3_input_a <= 1'b0;
      timer3_input_b <= 1'b0;
      timer1_capture_b <= 1'b0;
      timer1_io_a <= 1'b0;
      external_interrupt_input <= 1'b0;
      serial_data_in <= 1'b0;
      serial_shift_clock <= 1'b0;
      halt_wake <= 1'b0;
    end
    else
    begin
      halt_mode <= power == mpio_pkg::MPIO_HALT;
      idle_mode <= power == mpio_pkg::MPIO_IDLE;
      restart_delay_enable <= g_conf[`MPIO_G_DLY_BIT] &&
                              rc_osc_option;
      serial_clock_phase_select <= g_conf[`MPIO_G_PHASE_BIT];
      multi_input_wakeup <= l_s2;
      timer2_input_a <= l_s2[4];
      timer2_input_b <= l_s2[5];
      timer3_input_a <= l_s2[6];
      timer3_input_b <= l_s2[7];
      serial_data_in <= g_s2[6];
      serial_shift_clock <= g_s2[5];
      timer1_io_a <= g_s2[3];
      timer1_capture_b <= g_s2[2];
      external_interrupt_input <= g_s2[0];
      halt_wake <= g7_rise && power == mpio_pkg::MPIO_HALT;
    end
  end

  // Read port: data one cycle after the read strobe
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `MPIO_L_DATA: reg_rdata <= l_data;
        `MPIO_L_CONF: reg_rdata <= l_conf;
        `MPIO_L_PINS: reg_rdata <= l_s2;
        `MPIO_G_DATA: reg_rdata <= {2'b00, g_data[5:0]};
        `MPIO_G_CONF: reg_rdata <= g_conf;
        `MPIO_G_PINS: reg_rdata <= g_s2;
        `MPIO_C_DATA: reg_rdata <= c_data;
        `MPIO_C_CONF: reg_rdata <= c_conf;
        `MPIO_C_PINS: reg_rdata <= c_s2;
        `MPIO_I_PINS: reg_rdata <= i_s2;
        `MPIO_D_DATA: reg_rdata <= d_data;
        `MPIO_MODE_CTRL: reg_rdata <= {6'h00, idle_mode, halt_mode};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  chk_g_read_zero: assert property (@(posedge clk)
    disable iff (!resetn)
    reg_rd && reg_addr == `MPIO_G_DATA |=> reg_rdata[7:6] == 2'b00)
    else $error("G data bits 7:6 not zero on read");

  chk_halt_entry: assert property (@(posedge clk)
    disable iff (!resetn)
    reg_wr && reg_addr == `MPIO_G_DATA && reg_wdata[7]
    |=> ##1 halt_mode)
    else $error("HALT not entered");

  chk_idle_entry: assert property (@(posedge clk)
    disable iff (!resetn)
    reg_wr && reg_addr == `MPIO_G_DATA && reg_wdata[7:6] == 2'b01
    |=> ##1 idle_mode)
    else $error("IDLE not entered");

  chk_phase_sel: assert property (@(posedge clk)
    disable iff (!resetn)
    reg_wr && reg_addr == `MPIO_G_CONF
    |=> ##1 serial_clock_phase_select == $past(reg_wdata[6], 2))
    else $error("Serial phase select wrong");

  chk_drive_map: assert property (@(posedge clk)
    disable iff (!resetn)
    port_c_oe == $past(c_conf) && port_c_out == $past(c_data))
    else $error("Port C drive does not follow config/data");

  chk_pin_sync: assert property (@(posedge clk)
    disable iff (!resetn)
    reg_rd && reg_addr == `MPIO_I_PINS
    |=> reg_rdata == $past(port_i_in, 3))
    else $error("Port I read not two-flop synchronised");

  chk_g6_input: assert property (@(posedge clk)
    disable iff (!resetn)
    !port_g_oe[6] && !port_g_pullup[6])
    else $error("G6 driven");

  chk_osc_pin: assert property (@(posedge clk)
    disable iff (!resetn)
    port_g_oe[7] == !$past(rc_osc_option))
    else $error("G7 drive disagrees with oscillator option");

  chk_wake_map: assert property (@(posedge clk)
    disable iff (!resetn)
    ##1 multi_input_wakeup == $past(l_s2)
    && timer3_input_b == $past(l_s2[7]))
    else $error("Port L wake-up routing wrong");

  chk_delay_en: assert property (@(posedge clk)
    disable iff (!resetn)
    restart_delay_enable == $past(g_conf[7] && rc_osc_option))
    else $error("Restart delay enable wrong");

  // Pin reads see the pins three edges back: two sync flops, one read flop
  chk_l_pin_read: assert property (@(posedge clk)
    disable iff (!resetn)
    reg_rd && reg_addr == `MPIO_L_PINS
    |=> reg_rdata == $past(port_l_in, 3))
    else $error("Port L pin read wrong");

  chk_c_pin_read: assert property (@(posedge clk)
    disable iff (!resetn)
    reg_rd && reg_addr == `MPIO_C_PINS
    |=> reg_rdata == $past(port_c_in, 3))
    else $error("Port C pin read wrong");

  chk_alt_inputs: assert property (@(posedge clk)
    disable iff (!resetn)
    serial_shift_clock == $past(g_s2[5]) && timer1_io_a == $past(g_s2[3])
    && timer1_capture_b == $past(g_s2[2])
    && external_interrupt_input == $past(g_s2[0]))
    else $error("Port G alternate inputs misrouted");

  chk_l_drive: assert property (@(posedge clk)
    disable iff (!resetn)
    port_l_oe == $past(l_conf) && port_l_pullup == $past(~l_conf & l_data))
    else $error("Port L drive does not follow config/data");

  chk_fault_pin: assert property (@(posedge clk)
    disable iff (!resetn)
    port_g_oe[1] == !$past(fault_monitor_n) && !port_g_out[1])
    else $error("Fault pin drive wrong");

  chk_halt_wake: assert property (@(posedge clk)
    disable iff (!resetn)
    g7_rise && power == mpio_pkg::MPIO_HALT && !reg_wr
    |=> halt_wake && power == mpio_pkg::MPIO_RUN)
    else $error("G7 rise did not leave HALT");

endmodule // mpio_top

// file: core/mpio_map.svh
`ifndef MPIO_MAP_SVH
`define MPIO_MAP_SVH
// Register indices on the plain register port
`define MPIO_ADDR_W 4
`define MPIO_L_DATA 4'h0
`define MPIO_L_CONF 4'h1
`define MPIO_L_PINS 4'h2
`define MPIO_G_DATA 4'h4
`define MPIO_G_CONF 4'h5
`define MPIO_G_PINS 4'h6
`define MPIO_C_DATA 4'h8
`define MPIO_C_CONF 4'h9
`define MPIO_C_PINS 4'ha
`define MPIO_I_PINS 4'hb
`define MPIO_D_DATA 4'hc
`define MPIO_MODE_CTRL 4'hd
// Field positions in port G registers
`define MPIO_G_HALT_BIT 7
`define MPIO_G_IDLE_BIT 6
`define MPIO_G_DLY_BIT 7
`define MPIO_G_PHASE_BIT 6
`define MPIO_G_FAULT_BIT 1
// Bits of port G that are general I/O: G0, G2..G5
`define MPIO_G_GPIO_MASK 8'h3d
// Reset values
`define MPIO_PORT_RST 8'h00
`define MPIO_D_RST 8'hff
`endif

// file: core/mpio_pkg.sv
package mpio_pkg;
  typedef enum logic [1:0] {
    MPIO_RUN = 2'b00,
    MPIO_HALT = 2'b01,
    MPIO_IDLE = 2'b10
  } mpio_power_t;
endpackage

// file: sim/mpio_board.sv
`timescale 1ns/1ns
module mpio_board (
  input wire logic clk,
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin
);
  logic wobble = 1'b0;
  // A floating line moves every cycle so a stale level never reads right
  always @(posedge clk)
    wobble <= ~wobble;
  always_comb
    for (int b = 0; b < 8; b++)
      if (oe[b])
        pin[b] = out[b];
      else if (ext_en[b])
        pin[b] = ext_val[b];
      else
        pin[b] = pull_en[b] | (wobble ^ b[0]);
endmodule // mpio_board

// file: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0, p;
  logic [7:0] reg_wdata = 8'h00, port_i_in = 8'h00, reg_rdata, rv, c, d, e, x;
  logic rc_osc_option = 1'b1, fault_monitor_n = 1'b1, restart_done = 1'b0;
  logic osc_clock_in = 1'b0, serial_data_out = 1'b0, serial_clock_out = 1'b0;
  logic serial_clock_drive = 1'b0, timer1_out = 1'b0, timer1_drive = 1'b0;
  wire [7:0] port_l_in, port_g_in, port_c_in;
  logic [7:0] port_l_out, port_l_oe, port_l_pullup, port_g_out, port_g_oe;
  logic [7:0] port_g_pullup, port_c_out, port_c_oe, port_c_pullup;
  logic [7:0] port_d_out, multi_input_wakeup;
  logic [2:0][7:0] ext = '0, en = '0;
  logic halt_mode, idle_mode, restart_delay_enable, serial_clock_phase_select;
  logic timer2_input_a, timer2_input_b, timer3_input_a, timer3_input_b;
  logic timer1_capture_b, timer1_io_a, external_interrupt_input;
  logic serial_data_in, serial_shift_clock, halt_wake, w;
  logic [31:0] seed = 32'h24dbe064;
  int fail_count = 0, checks_done = 0;
  always #4 clk = ~clk;
  mpio_top mpio_top_i (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .port_l_in, .port_l_out, .port_l_oe,
    .port_l_pullup, .port_g_in, .port_g_out, .port_g_oe, .port_g_pullup,
    .port_c_in, .port_c_out, .port_c_oe, .port_c_pullup, .port_i_in,
    .port_d_out, .rc_osc_option, .osc_clock_in, .fault_monitor_n,
    .serial_data_out, .serial_clock_out, .serial_clock_drive, .timer1_out,
    .timer1_drive, .restart_done, .halt_mode, .idle_mode,
    .restart_delay_enable, .serial_clock_phase_select, .multi_input_wakeup,
    .timer2_input_a, .timer2_input_b, .timer3_input_a, .timer3_input_b,
    .timer1_capture_b, .timer1_io_a, .external_interrupt_input,
    .serial_data_in, .serial_shift_clock, .halt_wake);
  mpio_board mpio_board_i [2:0] (.clk,
    .out({port_c_out, port_g_out, port_l_out}),
    .oe({port_c_oe, port_g_oe, port_l_oe}),
    .pull_en({port_c_pullup, port_g_pullup, port_l_pullup}),
    .ext_val(ext), .ext_en(en), .pin({port_c_in, port_g_in, port_l_in}));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Driven bits show the data register, the rest what the board drives
  function automatic logic [7:0] pin_exp(input logic [7:0] cf, dt, ex);
    return (cf & dt) | (~cf & ex);
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    settle();
    chk("port d in reset", port_d_out, 8'hff);
    chk("port l drive in reset", port_l_oe, 8'h00);
    @(posedge clk);
    resetn <= 1'b1;
    rd(4'h9);
    chk("port c conf after reset", rv, 8'h00);
    rd(4'hf);
    chk("unmapped read", rv, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 24; i++)
    begin
      p = i[0] ? 4'h8 : 4'h0;
      c = rnd();
      d = rnd();
      e = rnd();
      x = pin_exp(c, d, e);
      wr(p + 4'h1, c);
      wr(p, d);
      {serial_data_out, timer1_out, port_i_in} <= {e[1:0], rnd()};
      ext[p[3:2]] <= e;
      en[p[3:2]] <= ~c;
      settle();
      chk("drive enable", i[0] ? port_c_oe : port_l_oe, c);
      chk("pull-up", i[0] ? port_c_pullup : port_l_pullup, ~c & d);
      chk("drive level", (i[0] ? port_c_out : port_l_out) & c, d & c);
      rd(p);
      chk("data readback", rv, d);
      rd(p + 4'h1);
      chk("conf readback", rv, c);
      rd(p + 4'h2);
      chk("pin levels", rv, x);
      rd(4'hb);
      chk("port i", rv, port_i_in);
      if (!i[0])
      begin
        chk("wakeup", multi_input_wakeup, x);
        rv = {timer3_input_b, timer3_input_a, timer2_input_b,
          timer2_input_a, 4'h0};
        chk("timers", rv, x & 8'hf0);
      end
    end
    $display("port test done");
    x = rnd() & 8'h7f;
    wr(4'hc, x);
    settle();
    chk("port d", port_d_out, x);
    @(posedge clk);
    resetn <= 1'b0;
    settle();
    chk("port d in midrun reset", port_d_out, 8'hff);
    chk("port c drive in reset", port_c_oe, 8'h00);
    @(posedge clk);
    resetn <= 1'b1;
    rd(4'h8);
    chk("port c data after reset", rv, 8'h00);
    $display("midrun reset test done");
    @(posedge clk);
    ext[1] <= 8'h40;
    en[1] <= 8'hc0;
    wr(4'h5, 8'hc0);
    settle();
    chk("phase", serial_clock_phase_select, 1'b1);
    chk("delay", restart_delay_enable, 1'b1);
    chk("serial in", serial_data_in, 1'b1);
    wr(4'h4, 8'hff);
    settle();
    chk("halt", {idle_mode, halt_mode}, 8'h01);
    rd(4'h4);
    chk("g data read", rv, 8'h3f);
    @(posedge clk);
    fault_monitor_n <= 1'b0;
    settle();
    chk("fault pin", {port_g_oe[1], port_g_out[1]}, 8'h02);
    @(posedge clk);
    fault_monitor_n <= 1'b1;
    ext[1] <= 8'hc0;
    w = 1'b0;
    repeat (6)
    begin
      @(posedge clk);
      #1 w = w | halt_wake;
    end
    chk("g7 wake", halt_mode, 1'b0);
    chk("g7 wake pulse", w, 1'b1);
    wr(4'h4, 8'h40);
    settle();
    rd(4'hd);
    chk("idle", rv, 8'h02);
    @(posedge clk);
    restart_done <= 1'b1;
    @(posedge clk);
    restart_done <= 1'b0;
    settle();
    chk("idle left", idle_mode, 1'b0);
    @(posedge clk);
    rc_osc_option <= 1'b0;
    settle();
    chk("delay crystal", restart_delay_enable, 1'b0);
    chk("clock out", port_g_oe[7], 1'b1);
    $display("port g test done");
    test_done();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule // tb_top
